// [bench/mbcr_top_sva.sv]
// Purpose: Port assertions for the bank-0 control registers
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to the top module below the checker
module mbcr_top_sva (
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic CTRL_READ_OP_IN,
    input wire logic PORT_READ_OP_IN,
    input wire logic [3:0] PORT_INDEX_IN,
    input wire logic IRQ_OFF_OP_IN,
    input wire logic IRQ_ON_OP_IN,
    input wire logic IRQ_RETURN_OP_IN,
    input wire logic REMOTE_WAKE_SUPPORT_IN,
    input wire logic [1:0] BASE_TIMEOUT_SEL_IN,
    input wire logic NORMAL_CLK_SEL_IN,
    input wire logic [7:0] RD_DATA_OUT,
    input wire logic RD_VALID_OUT,
    input wire logic IRQ_DISABLE_OUT,
    input wire logic [7:0] DOG_RATIO_OUT,
    input wire logic [8:0] TICK_RATIO_OUT,
    input wire logic [20:0] DOG_TIMEOUT_US_OUT,
    input wire logic [7:0] SAMPLE_CLKS_OUT,
    input wire logic [2:0] DEBOUNCE_SEL_OUT,
    input wire logic [9:0] DEBOUNCE_CLKS_OUT,
    input wire logic [1:0] OP_MODE_OUT,
    input wire logic [1:0] PORT_TYPE_OUT,
    input wire logic PORT_TYPE_VALID_OUT,
    input wire logic CORE_SLOW_CLK_OUT,
    input wire logic USB_CORE_STOP_OUT,
    input wire logic LP_TICK_OUT
);
    // One clock and reset
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    // Base timeout per select code, microseconds
    localparam logic [20:0] BASE [4] =
        '{21'h01F4, 21'h07D0, 21'h1F40, 21'h3E80};

    a_read_valid_pulse: assert property (
        (CTRL_READ_OP_IN || PORT_READ_OP_IN) |=> RD_VALID_OUT)
        else $error("read strobe without valid");
    a_no_stray_valid: assert property (
        !(CTRL_READ_OP_IN || PORT_READ_OP_IN) |=> !RD_VALID_OUT)
        else $error("valid without read strobe");
    a_ctrl_read_bits: assert property (
        CTRL_READ_OP_IN |=> RD_DATA_OUT[7] == $past(REMOTE_WAKE_SUPPORT_IN)
        && RD_DATA_OUT[6] == $past(IRQ_DISABLE_OUT))
        else $error("control read bits wrong");
    a_unmapped_zero: assert property (
        PORT_READ_OP_IN && !CTRL_READ_OP_IN
        && (PORT_INDEX_IN < 4'h5 || PORT_INDEX_IN > 4'hB)
        |=> RD_DATA_OUT == 8'h00)
        else $error("unmapped read not zero");
    a_dl_upper_zero: assert property (
        PORT_READ_OP_IN && !CTRL_READ_OP_IN && PORT_INDEX_IN == 4'h5
        |=> RD_DATA_OUT[7:2] == 6'h00)
        else $error("data-line upper bits set");
    a_irq_off_wins: assert property (
        IRQ_OFF_OP_IN |=> IRQ_DISABLE_OUT)
        else $error("interrupts not disabled");
    a_irq_on_clear: assert property (
        (IRQ_ON_OP_IN || IRQ_RETURN_OP_IN) && !IRQ_OFF_OP_IN
        |=> !IRQ_DISABLE_OUT)
        else $error("interrupts not enabled");
    a_ratio_shape: assert property (
        $onehot(DOG_RATIO_OUT) && $onehot(TICK_RATIO_OUT)
        && !TICK_RATIO_OUT[0])
        else $error("prescale ratio malformed");
    a_timeout_product: assert property (
        !$past(SYS_RST_IN) |-> DOG_TIMEOUT_US_OUT
        == BASE[$past(BASE_TIMEOUT_SEL_IN)] * DOG_RATIO_OUT)
        else $error("timeout not base times ratio");
    a_debounce_product: assert property (
        $onehot(SAMPLE_CLKS_OUT)
        && DEBOUNCE_CLKS_OUT == DEBOUNCE_SEL_OUT * SAMPLE_CLKS_OUT)
        else $error("debounce not code times sample");
    a_slow_follow: assert property (
        !$past(SYS_RST_IN) |-> CORE_SLOW_CLK_OUT == !$past(NORMAL_CLK_SEL_IN)
        && USB_CORE_STOP_OUT == CORE_SLOW_CLK_OUT)
        else $error("slow clock or stop wrong");
    a_tick_fast_quiet: assert property (
        !CORE_SLOW_CLK_OUT [*3] |-> !LP_TICK_OUT)
        else $error("low-power tick in normal mode");
    a_detect_result: assert property (
        $rose(PORT_TYPE_VALID_OUT) |-> OP_MODE_OUT == 2'h0
        && PORT_TYPE_OUT != 2'h0)
        else $error("port type valid outside detect");

    // Main scenarios reached
    c_ctrl_read: cover property (CTRL_READ_OP_IN);
    c_irq_clash: cover property (IRQ_OFF_OP_IN && IRQ_ON_OP_IN);
    c_lp_tick: cover property (LP_TICK_OUT);
    c_detected: cover property ($rose(PORT_TYPE_VALID_OUT));
endmodule

bind mbcr_top mbcr_top_sva u_sva (.*);

// [bench/tb_mbcr_top.sv]
// Purpose: Bench for bank-0 control registers
// Assumes: Small divide counts
// Notes: Seeded random and corner cases
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin \
    n_fail++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); end end

module tb_mbcr_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, wake, nclk, dp, dm;
    logic [7:0] st, wd, acc_q, rdd, p7d, dog, smp, cnt, d;
    logic [3:0] idx;
    logic [7:0] m [16];
    logic [1:0] bsel, dld, dra, drb, opm, lpf, pty;
    logic [7:1] p6d, pul;
    logic [8:0] tick;
    logic [20:0] tmo;
    logic [2:0] dbs;
    logic [9:0] dbc;
    logic rdv, irqd, pval, slow, stop, lpt;
    int n_fail, comparisons, k;
    logic [20:0] base [4] = '{21'h01F4, 21'h07D0, 21'h1F40, 21'h3E80};
    logic [7:0] lp_n [4] = '{8'h06, 8'h08, 8'h0C, 8'h18};
    logic [7:0] irq_seq [6] = '{8'h10, 8'h20, 8'h10, 8'h40, 8'h30, 8'h44};
    logic [5:0] irq_exp = 6'b01_0101;

    mbcr_top #(.LP_DIV_0(8), .LP_DIV_1(6), .LP_DIV_2(4), .LP_DIV_3(2)) dut_u (
        .CLK_IN(clk),
        .SYS_RST_IN(rst),
        .ACC_WR_IN(st[7]),
        .ACC_DATA_IN(wd),
        .CTRL_READ_OP_IN(st[3]),
        .CTRL_WRITE_OP_IN(st[2]),
        .IRQ_OFF_OP_IN(st[4]),
        .IRQ_ON_OP_IN(st[5]),
        .IRQ_RETURN_OP_IN(st[6]),
        .PORT_READ_OP_IN(st[1]),
        .PORT_WRITE_OP_IN(st[0]),
        .PORT_INDEX_IN(idx),
        .WR_DATA_IN(wd),
        .REMOTE_WAKE_SUPPORT_IN(wake),
        .BASE_TIMEOUT_SEL_IN(bsel),
        .NORMAL_CLK_SEL_IN(nclk),
        .DATA_PLUS_IN(dp),
        .DATA_MINUS_IN(dm),
        .ACC_OUT(acc_q),
        .RD_DATA_OUT(rdd),
        .RD_VALID_OUT(rdv),
        .IRQ_DISABLE_OUT(irqd),
        .DOG_RATIO_OUT(dog),
        .TICK_RATIO_OUT(tick),
        .DOG_TIMEOUT_US_OUT(tmo),
        .DATA_LINE_DIR_OUT(dld),
        .PORT_SIX_DIR_OUT(p6d),
        .PORT_SEVEN_DIR_OUT(p7d),
        .DRIVE_LEVEL_A_OUT(dra),
        .DRIVE_LEVEL_B_OUT(drb),
        .SAMPLE_CLKS_OUT(smp),
        .DEBOUNCE_SEL_OUT(dbs),
        .DEBOUNCE_CLKS_OUT(dbc),
        .OP_MODE_OUT(opm),
        .LP_FREQ_SEL_OUT(lpf),
        .PULL_LOW_ENABLE_OUT(pul),
        .PORT_TYPE_OUT(pty),
        .PORT_TYPE_VALID_OUT(pval),
        .CORE_SLOW_CLK_OUT(slow),
        .USB_CORE_STOP_OUT(stop),
        .LP_TICK_OUT(lpt)
    );

    // Core clock, 20 ns period
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Implemented bits per register index
    function automatic logic [7:0] msk(input logic [3:0] i);
        case (i)
            4'h5: msk = 8'h03;
            4'h6, 4'hB: msk = 8'hFE;
            4'h7: msk = 8'hFF;
            4'h8: msk = 8'h33;
            4'h9: msk = 8'h77;
            4'hA: msk = 8'hC3;
            default: msk = 8'h00;
        endcase
    endfunction

    // One-cycle strobe set
    task automatic op(input logic [7:0] s, input logic [3:0] i,
                      input logic [7:0] dv);
        @(posedge clk);
        st <= s;
        idx <= i;
        wd <= dv;
        @(posedge clk);
        st <= 8'h00;
    endtask

    // Read and compare
    task automatic rd(input logic [3:0] i, input logic [7:0] e,
                      input logic c);
        op(c ? 8'h08 : 8'h02, i, 8'h00);
        #1;
        `CHK("rd_valid", 1'b1, rdv)
        `CHK("rd_data", e, rdd)
    endtask

    // Field outputs vs model
    task automatic outs();
        `CHK("dl_dir", m[5][1:0], dld)
        `CHK("p6_dir", m[6][7:1], p6d)
        `CHK("p7_dir", m[7], p7d)
        `CHK("drive_a", m[8][1:0], dra)
        `CHK("drive_b", m[8][5:4], drb)
        `CHK("sample", 8'h01 << m[9][6:4], smp)
        `CHK("deb_sel", m[9][2:0], dbs)
        `CHK("deb_clk", {7'h00, m[9][2:0]} << m[9][6:4], dbc)
        `CHK("op_mode", m[10][1:0], opm)
        `CHK("lp_freq", m[10][7:6], lpf)
        `CHK("pull_low", m[11][7:1], pul)
    endtask

    // Verdict and end of run
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        final_report();
    end

    // Main sequence
    initial begin
        st = 8'h00;
        idx = 4'h0;
        wd = 8'h00;
        {wake, bsel, dp, dm} = 5'h00;
        nclk = 1'b1;
        rst = 1'b1;
        void'($urandom(65993));
        m = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'hFE, 8'hFF,
              8'h00, 8'h70, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 16; i++)
            rd(i[3:0], m[i], 1'b0);
        rd(4'h0, 8'h3F, 1'b1);
        outs();
        `CHK("dog", 8'h80, dog)
        `CHK("tick", 9'h100, tick)
        $display("test reset done");
        // Random writes, accumulator alongside
        for (int n = 0; n < 40; n++) begin
            k = $urandom_range(15);
            d = 8'($urandom);
            op(8'h81, k[3:0], d);
            m[k] = d & msk(k[3:0]);
            #1;
            `CHK("acc", d, acc_q)
            outs();
            rd(k[3:0], m[k], 1'b0);
        end
        // Read during write sees old value
        op(8'h03, 4'h8, 8'hFF);
        #1;
        `CHK("rd_old", m[8], rdd)
        m[8] = 8'h33;
        $display("test random done");
        // Every field code
        for (int c = 0; c < 8; c++) begin
            @(posedge clk);
            bsel <= c[1:0];
            wake <= c[0];
            op(8'h04, 4'h0, {2'b10, c[2:0], c[2:0]});
            m[8] = {2'b00, c[1:0], 2'b00, c[1:0]};
            m[9] = {1'b0, c[2:0], 1'b0, c[2:0]};
            m[10] = {c[1:0], 4'h0, c[1:0]};
            for (int r = 8; r < 11; r++)
                op(8'h01, r[3:0], m[r]);
            #1;
            outs();
            `CHK("dog", 8'h01 << c, dog)
            `CHK("tick", 9'h002 << c, tick)
            `CHK("tmo", base[c[1:0]] << c, tmo)
            rd(4'h0, {c[0], 1'b0, c[2:0], c[2:0]}, 1'b1);
        end
        $display("test fields done");
        // Interrupt ops and clashes
        for (int j = 0; j < 6; j++) begin
            op(irq_seq[j], 4'h0, 8'h40);
            #1;
            `CHK("irq_off", irq_exp[j], irqd)
        end
        $display("test irq done");
        // Slow clock tick counts
        @(posedge clk);
        nclk <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK("slow", 1'b1, slow)
        `CHK("usb_stop", 1'b1, stop)
        for (int f = 0; f < 4; f++) begin
            op(8'h01, 4'hA, {f[1:0], 6'h01});
            repeat (12) @(posedge clk);
            cnt = 8'h00;
            repeat (48) begin
                @(posedge clk);
                #1;
                cnt += {7'h00, lpt};
            end
            `CHK("lp_ticks", lp_n[f], cnt)
        end
        @(posedge clk);
        nclk <= 1'b1;
        $display("test slow done");
        // Host port detection
        for (int t = 1; t < 3; t++) begin
            op(8'h01, 4'hA, 8'hC1);
            @(posedge clk);
            dp <= 1'b1;
            dm <= t[1];
            op(8'h01, 4'hA, 8'hC0);
            @(posedge clk);
            #1;
            `CHK("det_clear", 1'b0, pval)
            for (k = 0; k < 700 && pval !== 1'b1; k++)
                @(posedge clk);
            #1;
            `CHK("det_valid", 1'b1, pval)
            `CHK("det_type", t[1:0], pty)
        end
        $display("test detect done");
        final_report();
    end
endmodule

// [common/mbcr_pkg.sv]
// Purpose: Types shared by the bank-0 control register block
// Assumes: Constants come from mbcr_regs.svh
// Notes: Types only
package mbcr_pkg;

    // Operation mode codes
    typedef enum logic [1:0] {
        MBCR_MODE_DETECT = 2'h0,
        MBCR_MODE_USB = 2'h1,
        MBCR_MODE_LEGACY = 2'h2,
        MBCR_MODE_TEST = 2'h3
    } mbcr_mode_t;

    // Host-port detector states, one-hot
    typedef enum logic [2:0] {
        MBCR_DET_IDLE = 3'b001,
        MBCR_DET_WATCH = 3'b010,
        MBCR_DET_DONE = 3'b100
    } mbcr_det_t;

    // State of the top module, apart from the LP_TICK_OUT flop
    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] ctrl;
        logic [7:0] dl_dir;
        logic [7:0] p6_dir;
        logic [7:0] p7_dir;
        logic [7:0] sink;
        logic [7:0] pat;
        logic [7:0] mode;
        logic [7:0] pull;
        logic [7:0] rd_data;
        logic rd_valid;
        logic [7:0] dog_ratio;
        logic [8:0] tick_ratio;
        logic [20:0] dog_tmo;
        logic [7:0] smp_clks;
        logic [9:0] deb_clks;
        mbcr_det_t det_state;
        logic [15:0] det_cnt;
        logic [1:0] det_cand;
        logic [1:0] port_type;
        logic port_valid;
        logic slow_run;
        logic usb_stop;
    } mbcr_state_t;

endpackage

// [common/mbcr_regs.svh]
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Core clock of 50 MHz; eight-bit control registers
// Notes: Definitions only, included by the top module
`ifndef MBCR_REGS_SVH
`define MBCR_REGS_SVH

// Port register indices
`define MBCR_IDX_DL_DIR 4'h5
`define MBCR_IDX_P6_DIR 4'h6
`define MBCR_IDX_P7_DIR 4'h7
`define MBCR_IDX_SINK 4'h8
`define MBCR_IDX_PAT 4'h9
`define MBCR_IDX_MODE 4'hA
`define MBCR_IDX_PULL 4'hB

// Reset values
`define MBCR_RST_CTRL 8'h3F
`define MBCR_RST_DL_DIR 8'h03
`define MBCR_RST_P6_DIR 8'hFE
`define MBCR_RST_P7_DIR 8'hFF
`define MBCR_RST_SINK 8'h00
`define MBCR_RST_PAT 8'h70
`define MBCR_RST_MODE 8'hC0
`define MBCR_RST_PULL 8'h00

// Implemented-bit masks
`define MBCR_MASK_CTRL 8'h7F
`define MBCR_MASK_DL 8'h03
`define MBCR_MASK_P6 8'hFE
`define MBCR_MASK_P7 8'hFF
`define MBCR_MASK_SINK 8'h33
`define MBCR_MASK_PAT 8'h77
`define MBCR_MASK_MODE 8'hC3

// Field positions
`define MBCR_CTRL_DOG_LSB 0
`define MBCR_CTRL_TICK_LSB 3
`define MBCR_CTRL_IRQ_OFF 6
`define MBCR_CTRL_WAKE 7
`define MBCR_SINK_A_LSB 0
`define MBCR_SINK_B_LSB 4
`define MBCR_PAT_DEB_LSB 0
`define MBCR_PAT_SMP_LSB 4
`define MBCR_MODE_LSB 0
`define MBCR_LPF_LSB 6

// Watchdog base periods, us
`define MBCR_BASE_US_0 500
`define MBCR_BASE_US_1 2000
`define MBCR_BASE_US_2 8000
`define MBCR_BASE_US_3 16000

// Clock rates in hertz
`define MBCR_CLK_HZ 50000000
`define MBCR_LP_HZ_0 500
`define MBCR_LP_HZ_1 4000
`define MBCR_LP_HZ_2 32000
`define MBCR_LP_HZ_3 256000

// Host-port detect stable time
`define MBCR_DET_STABLE_US 10
`define MBCR_DET_STABLE_CYC \
    ((`MBCR_DET_STABLE_US * (`MBCR_CLK_HZ / 1000000)))

`endif

// [core/mbcr_lp_div.sv]
// Purpose: Low-power rate tick generator
// Assumes: Divide counts from core clock rate
// Notes: Restarts on select change
module mbcr_lp_div #(
    parameter int DIV_0 = 100000,
    parameter int DIV_1 = 12500,
    parameter int DIV_2 = 1562,
    parameter int DIV_3 = 195
) (
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [1:0] sel_in,
    output logic tick_out
);

    logic [16:0] count; // Cycles since last tick
    logic [16:0] limit; // Terminal count for current select
    logic [1:0] sel_q; // Select seen last cycle

    // Terminal count lookup
    always_comb begin
        unique case (sel_in)
            2'h0: limit = 17'(DIV_0 - 1);
            2'h1: limit = 17'(DIV_1 - 1);
            2'h2: limit = 17'(DIV_2 - 1);
            2'h3: limit = 17'(DIV_3 - 1);
        endcase
    end

    // Free-running divider
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            count <= '0;
            tick_out <= 1'b0;
            sel_q <= 2'h0;
        end else begin
            sel_q <= sel_in;
            tick_out <= 1'b0;
            if (sel_q != sel_in || count >= limit) begin
                count <= '0;
                tick_out <= (sel_q == sel_in);
            end else begin
                count <= count + 17'h0_0001;
            end
        end
    end

endmodule

// [core/mbcr_sync.sv]
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Synchronous active-high reset
// Notes: First stage feeds only the second stage
module mbcr_sync #(
    parameter int WIDTH = 2
) (
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one; // Metastability catcher

    // Two stages, reset to zero
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            stage_one <= '0;
            sync_out <= '0;
        end else begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end

endmodule

// [core/mbcr_top.sv]
// Purpose: Bank-0 control registers of a small USB microcontroller
// Assumes: Instruction strobes come from the core on CLK_IN
// Notes: Bus lines from pins pass a two-flop synchroniser
`include "mbcr_regs.svh"

module mbcr_top #(
    parameter int LP_DIV_0 = `MBCR_CLK_HZ / `MBCR_LP_HZ_0,
    parameter int LP_DIV_1 = `MBCR_CLK_HZ / `MBCR_LP_HZ_1,
    parameter int LP_DIV_2 = `MBCR_CLK_HZ / `MBCR_LP_HZ_2,
    parameter int LP_DIV_3 = `MBCR_CLK_HZ / `MBCR_LP_HZ_3
) (
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic ACC_WR_IN,
    input wire logic [7:0] ACC_DATA_IN,
    input wire logic CTRL_READ_OP_IN,
    input wire logic CTRL_WRITE_OP_IN,
    input wire logic IRQ_OFF_OP_IN,
    input wire logic IRQ_ON_OP_IN,
    input wire logic IRQ_RETURN_OP_IN,
    input wire logic PORT_READ_OP_IN,
    input wire logic PORT_WRITE_OP_IN,
    input wire logic [3:0] PORT_INDEX_IN,
    input wire logic [7:0] WR_DATA_IN,
    input wire logic REMOTE_WAKE_SUPPORT_IN,
    input wire logic [1:0] BASE_TIMEOUT_SEL_IN,
    input wire logic NORMAL_CLK_SEL_IN,
    input wire logic DATA_PLUS_IN,
    input wire logic DATA_MINUS_IN,
    output logic [7:0] ACC_OUT,
    output logic [7:0] RD_DATA_OUT,
    output logic RD_VALID_OUT,
    output logic IRQ_DISABLE_OUT,
    output logic [7:0] DOG_RATIO_OUT,
    output logic [8:0] TICK_RATIO_OUT,
    output logic [20:0] DOG_TIMEOUT_US_OUT,
    output logic [1:0] DATA_LINE_DIR_OUT,
    output logic [7:1] PORT_SIX_DIR_OUT,
    output logic [7:0] PORT_SEVEN_DIR_OUT,
    output logic [1:0] DRIVE_LEVEL_A_OUT,
    output logic [1:0] DRIVE_LEVEL_B_OUT,
    output logic [7:0] SAMPLE_CLKS_OUT,
    output logic [2:0] DEBOUNCE_SEL_OUT,
    output logic [9:0] DEBOUNCE_CLKS_OUT,
    output logic [1:0] OP_MODE_OUT,
    output logic [1:0] LP_FREQ_SEL_OUT,
    output logic [7:1] PULL_LOW_ENABLE_OUT,
    output logic [1:0] PORT_TYPE_OUT,
    output logic PORT_TYPE_VALID_OUT,
    output logic CORE_SLOW_CLK_OUT,
    output logic USB_CORE_STOP_OUT,
    output logic LP_TICK_OUT
);

    // Reset image of the whole state
    localparam mbcr_pkg::mbcr_state_t RST_STATE = '{
        acc: 8'h00,
        ctrl: `MBCR_RST_CTRL & `MBCR_MASK_CTRL,
        dl_dir: `MBCR_RST_DL_DIR,
        p6_dir: `MBCR_RST_P6_DIR,
        p7_dir: `MBCR_RST_P7_DIR,
        sink: `MBCR_RST_SINK,
        pat: `MBCR_RST_PAT,
        mode: `MBCR_RST_MODE,
        pull: `MBCR_RST_PULL,
        rd_data: 8'h00,
        rd_valid: 1'b0,
        dog_ratio: 8'h80,
        tick_ratio: 9'h100,
        dog_tmo: 21'(`MBCR_BASE_US_0 * 128),
        smp_clks: 8'h80,
        deb_clks: 10'h000,
        det_state: mbcr_pkg::MBCR_DET_WATCH,
        det_cnt: 16'h0000,
        det_cand: 2'h0,
        port_type: 2'h0,
        port_valid: 1'b0,
        slow_run: 1'b0,
        usb_stop: 1'b0
    };

    mbcr_pkg::mbcr_state_t st; // Registered state
    mbcr_pkg::mbcr_state_t next_st; // Next state
    logic [1:0] line_sync; // Synchronised bus lines {plus, minus}
    logic lp_tick; // Low-power rate tick

    // Base timeout in microseconds for a select code
    function automatic logic [20:0] base_us(input logic [1:0] sel);
        logic [20:0] v;
        v = 21'(`MBCR_BASE_US_0);
        unique case (sel)
            2'h0: v = 21'(`MBCR_BASE_US_0);
            2'h1: v = 21'(`MBCR_BASE_US_1);
            2'h2: v = 21'(`MBCR_BASE_US_2);
            2'h3: v = 21'(`MBCR_BASE_US_3);
        endcase
        return v;
    endfunction

    // Ratio two to the power of a four-bit code
    function automatic logic [8:0] pow2(input logic [3:0] code);
        return 9'(9'h001 << code);
    endfunction

    // Masked write: undefined bits stay zero
    function automatic logic [7:0] masked(input logic [7:0] d,
                                          input logic [7:0] m);
        return d & m;
    endfunction

    // Bus lines come from pins
    mbcr_sync #(
        .WIDTH(2)
    ) u_line_sync (
        .CLK_IN(CLK_IN),
        .SYS_RST_IN(SYS_RST_IN),
        .async_in({DATA_PLUS_IN, DATA_MINUS_IN}),
        .sync_out(line_sync)
    );

    // Low-power tick
    mbcr_lp_div #(
        .DIV_0(LP_DIV_0),
        .DIV_1(LP_DIV_1),
        .DIV_2(LP_DIV_2),
        .DIV_3(LP_DIV_3)
    ) u_lp_div (
        .CLK_IN(CLK_IN),
        .SYS_RST_IN(SYS_RST_IN),
        .sel_in(st.mode[`MBCR_LPF_LSB +: 2]),
        .tick_out(lp_tick)
    );

    // Next-state logic
    always_comb begin
        logic [7:0] rd_word;
        rd_word = 8'h00;
        next_st = st;
        next_st.rd_valid = 1'b0;

        // Accumulator, private to the core
        if (ACC_WR_IN) begin
            next_st.acc = ACC_DATA_IN;
        end

        // Control word via its own write op; interrupt ops also set or clear bit 6
        if (CTRL_WRITE_OP_IN) begin
            next_st.ctrl = masked(WR_DATA_IN, `MBCR_MASK_CTRL);
        end

        // Interrupt ops beat a control write
        if (IRQ_OFF_OP_IN) begin
            next_st.ctrl[`MBCR_CTRL_IRQ_OFF] = 1'b1;
        end else if (IRQ_ON_OP_IN || IRQ_RETURN_OP_IN) begin
            next_st.ctrl[`MBCR_CTRL_IRQ_OFF] = 1'b0;
        end

        // Port register writes by index
        if (PORT_WRITE_OP_IN) begin
            unique case (PORT_INDEX_IN)
                `MBCR_IDX_DL_DIR: begin
                    next_st.dl_dir = masked(WR_DATA_IN, `MBCR_MASK_DL);
                end
                `MBCR_IDX_P6_DIR: begin
                    next_st.p6_dir = masked(WR_DATA_IN, `MBCR_MASK_P6);
                end
                `MBCR_IDX_P7_DIR: begin
                    next_st.p7_dir = masked(WR_DATA_IN, `MBCR_MASK_P7);
                end
                `MBCR_IDX_SINK: begin
                    next_st.sink = masked(WR_DATA_IN, `MBCR_MASK_SINK);
                end
                `MBCR_IDX_PAT: begin
                    next_st.pat = masked(WR_DATA_IN, `MBCR_MASK_PAT);
                end
                `MBCR_IDX_MODE: begin
                    next_st.mode = masked(WR_DATA_IN, `MBCR_MASK_MODE);
                end
                `MBCR_IDX_PULL: begin
                    next_st.pull = masked(WR_DATA_IN, `MBCR_MASK_P6);
                end
                default: begin
                    // Unmapped index: write ignored
                    next_st.pull = st.pull;
                end
            endcase
        end

        // Read mux
        if (CTRL_READ_OP_IN) begin
            rd_word = st.ctrl;
            rd_word[`MBCR_CTRL_WAKE] = REMOTE_WAKE_SUPPORT_IN;
            next_st.rd_valid = 1'b1;
        end else if (PORT_READ_OP_IN) begin
            next_st.rd_valid = 1'b1;
            unique case (PORT_INDEX_IN)
                `MBCR_IDX_DL_DIR: rd_word = st.dl_dir;
                `MBCR_IDX_P6_DIR: rd_word = st.p6_dir;
                `MBCR_IDX_P7_DIR: rd_word = st.p7_dir;
                `MBCR_IDX_SINK: rd_word = st.sink;
                `MBCR_IDX_PAT: rd_word = st.pat;
                `MBCR_IDX_MODE: rd_word = st.mode;
                `MBCR_IDX_PULL: rd_word = st.pull;
                default: rd_word = 8'h00;
            endcase
        end
        next_st.rd_data = next_st.rd_valid ? rd_word : st.rd_data;

        // Ratios and timeout
        next_st.dog_ratio = 8'(pow2({1'b0,
            next_st.ctrl[`MBCR_CTRL_DOG_LSB +: 3]}));
        next_st.tick_ratio = pow2({1'b0,
            next_st.ctrl[`MBCR_CTRL_TICK_LSB +: 3]} + 4'h1);
        next_st.dog_tmo = 21'(base_us(BASE_TIMEOUT_SEL_IN)
            << next_st.ctrl[`MBCR_CTRL_DOG_LSB +: 3]);

        // Sample and debounce lengths
        next_st.smp_clks = 8'(pow2({1'b0,
            next_st.pat[`MBCR_PAT_SMP_LSB +: 3]}));
        next_st.deb_clks = 10'(next_st.pat[`MBCR_PAT_DEB_LSB +: 3])
            * 10'(next_st.smp_clks);

        // Slow clock halts the USB core
        next_st.slow_run = ~NORMAL_CLK_SEL_IN;
        next_st.usb_stop = ~NORMAL_CLK_SEL_IN;

        // Host-port detector
        unique case (st.det_state)
            mbcr_pkg::MBCR_DET_IDLE: begin
                // Firmware returned to detect mode
                if (st.mode[`MBCR_MODE_LSB +: 2] ==
                        mbcr_pkg::MBCR_MODE_DETECT) begin
                    next_st.det_state = mbcr_pkg::MBCR_DET_WATCH;
                    next_st.det_cnt = 16'h0000;
                    next_st.port_valid = 1'b0;
                end
            end
            mbcr_pkg::MBCR_DET_WATCH: begin
                // Idle USB is plus high, minus low
                // Legacy port idles with both lines high
                if (st.mode[`MBCR_MODE_LSB +: 2] !=
                        mbcr_pkg::MBCR_MODE_DETECT) begin
                    next_st.det_state = mbcr_pkg::MBCR_DET_IDLE;
                end else if (line_sync == 2'b10 || line_sync == 2'b11) begin
                    if (line_sync != st.det_cand) begin
                        next_st.det_cand = line_sync;
                        next_st.det_cnt = 16'h0000;
                    end else if (st.det_cnt >=
                            16'(`MBCR_DET_STABLE_CYC - 1)) begin
                        next_st.det_state = mbcr_pkg::MBCR_DET_DONE;
                        next_st.port_valid = 1'b1;
                        next_st.port_type = (line_sync == 2'b10) ?
                            mbcr_pkg::MBCR_MODE_USB :
                            mbcr_pkg::MBCR_MODE_LEGACY;
                    end else begin
                        next_st.det_cnt = st.det_cnt + 16'h0001;
                    end
                end else begin
                    // Lines not in a recognised idle state
                    next_st.det_cand = 2'h0;
                    next_st.det_cnt = 16'h0000;
                end
            end
            mbcr_pkg::MBCR_DET_DONE: begin
                // Done holds until firmware picks a mode; result holds until detect mode returns
                if (st.mode[`MBCR_MODE_LSB +: 2] !=
                        mbcr_pkg::MBCR_MODE_DETECT) begin
                    next_st.det_state = mbcr_pkg::MBCR_DET_IDLE;
                end
            end
            default: begin
                // Illegal one-hot code recovers to idle
                next_st.det_state = mbcr_pkg::MBCR_DET_IDLE;
            end
        endcase
    end

    // State register with synchronous reset
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            st <= RST_STATE;
        end else begin
            st <= next_st;
        end
    end

    // Low-power tick, slow mode only
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            LP_TICK_OUT <= 1'b0;
        end else begin
            LP_TICK_OUT <= lp_tick & st.slow_run;
        end
    end

    // Outputs straight from state flops
    assign ACC_OUT = st.acc;
    assign RD_DATA_OUT = st.rd_data;
    assign RD_VALID_OUT = st.rd_valid;
    assign IRQ_DISABLE_OUT = st.ctrl[`MBCR_CTRL_IRQ_OFF];
    assign DOG_RATIO_OUT = st.dog_ratio;
    assign TICK_RATIO_OUT = st.tick_ratio;
    assign DOG_TIMEOUT_US_OUT = st.dog_tmo;
    assign DATA_LINE_DIR_OUT = st.dl_dir[1:0];
    assign PORT_SIX_DIR_OUT = st.p6_dir[7:1];
    assign PORT_SEVEN_DIR_OUT = st.p7_dir;
    assign DRIVE_LEVEL_A_OUT = st.sink[`MBCR_SINK_A_LSB +: 2];
    assign DRIVE_LEVEL_B_OUT = st.sink[`MBCR_SINK_B_LSB +: 2];
    assign SAMPLE_CLKS_OUT = st.smp_clks;
    assign DEBOUNCE_SEL_OUT = st.pat[`MBCR_PAT_DEB_LSB +: 3];
    assign DEBOUNCE_CLKS_OUT = st.deb_clks;
    assign OP_MODE_OUT = st.mode[`MBCR_MODE_LSB +: 2];
    assign LP_FREQ_SEL_OUT = st.mode[`MBCR_LPF_LSB +: 2];
    assign PULL_LOW_ENABLE_OUT = st.pull[7:1];
    assign PORT_TYPE_OUT = st.port_type;
    assign PORT_TYPE_VALID_OUT = st.port_valid;
    assign CORE_SLOW_CLK_OUT = st.slow_run;
    assign USB_CORE_STOP_OUT = st.usb_stop;

endmodule
